// ### rtl/pdrsis_pkg.sv
// shared constants for the rx stop / status block and its controller
package pdrsis_pkg;
    // ****************************************
    // link widths and timing
    // ****************************************
    localparam int AW           = 12;
    localparam int DW           = 32;
    localparam int LINK_HALF    = 10;
    // ****************************************
    // device register offsets
    // ****************************************
    localparam logic [11:0] OFS_RX_ENABLE  = 12'h400;
    localparam logic [11:0] OFS_RX_DISABLE = 12'h404;
    localparam logic [11:0] OFS_RX_DPTR    = 12'h408;
    localparam logic [11:0] OFS_STATUS     = 12'h500;
    localparam logic [11:0] OFS_MASK       = 12'h504;
    localparam logic [11:0] OFS_IRQ_EN     = 12'h508;
    localparam logic [31:0] REG_RESET      = 32'h0000_0000;
    localparam int          RUN_BIT        = 0;
    localparam int          STOP_BIT       = 0;
    localparam int          GIE_BIT        = 0;
    localparam int          PTR_LSB        = 2;
    // ****************************************
    // status bit positions
    // ****************************************
    localparam int ST_TX_BASE   = 0;
    localparam int ST_RX_BASE   = 4;
    localparam int ST_PCI_OFS   = 16;
    localparam int EV_IRQ       = 0;
    localparam int EV_OK        = 1;
    localparam int EV_ERR       = 2;
    localparam int EV_EOL       = 3;
    localparam int ST_TX_STARVE = 9;
    localparam int ST_RX_STARVE = 24;
    localparam int ST_EXT_INT   = 25;
    localparam int ST_MABORT    = 26;
    localparam logic [31:0] ST_USED = 32'h07FF_02FF;
    // ****************************************
    // controller register offsets
    // ****************************************
    localparam logic [7:0] H_OFS_CMD   = 8'h00;
    localparam logic [7:0] H_OFS_WDATA = 8'h04;
    localparam logic [7:0] H_OFS_RDATA = 8'h08;
    localparam logic [7:0] H_OFS_STAT  = 8'h0C;
    localparam logic [7:0] H_OFS_STOP  = 8'h10;
    localparam int         CMD_WR_BIT  = 16;
    localparam int         HS_BUSY     = 0;
    localparam int         HS_DONE     = 1;
    localparam int         HS_REFUSED  = 2;
    localparam int         HS_STOPPING = 3;
endpackage

// ### rtl/pdrsis_link_if.sv
// link between the controller and the rx stop / status device
`timescale 1ns/10ps
`default_nettype none
interface pdrsis_link_if;
    logic        lnk_clk;
    logic        lnk_req;
    logic        lnk_wr;
    logic [11:0] lnk_addr;
    logic [31:0] lnk_wdata;
    logic [31:0] lnk_rdata;
    modport dev (
        input  lnk_clk,
        input  lnk_req,
        input  lnk_wr,
        input  lnk_addr,
        input  lnk_wdata,
        output lnk_rdata
    );
    modport ctl (
        output lnk_clk,
        output lnk_req,
        output lnk_wr,
        output lnk_addr,
        output lnk_wdata,
        input  lnk_rdata
    );
endinterface
`default_nettype wire

// ### rtl/pdrsis_dev.sv
// rx shutdown control, rx descriptor pointer and interrupt status
`timescale 1ns/10ps
`default_nettype none
module pdrsis_dev (
    // clock and reset
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_in,
    // link to the controller
    pdrsis_link_if.dev                 link,
    // tx endpoint completion reports
    input  wire logic                  tx_done_in,
    input  wire logic                  tx_pci_in,
    input  wire logic                  tx_irq_req_in,
    input  wire logic                  tx_err_in,
    input  wire logic                  tx_null_link_in,
    input  wire logic                  tx_starve_in,
    // rx endpoint completion reports
    input  wire logic                  rx_done_in,
    input  wire logic                  rx_pci_in,
    input  wire logic                  rx_irq_req_in,
    input  wire logic                  rx_err_in,
    input  wire logic                  rx_null_link_in,
    input  wire logic                  rx_starve_in,
    input  wire logic                  rx_idle_in,
    input  wire logic                  rx_ptr_load_in,
    input  wire logic [pdrsis_pkg::DW-1:0] rx_ptr_next_in,
    // pci core
    input  wire logic                  host_mode_in,
    input  wire logic                  inta_n_in,
    input  wire logic                  mabort_in,
    // endpoint control and interrupt
    output logic                       rx_run_out,
    output logic                       rx_stop_req_out,
    output logic [pdrsis_pkg::DW-1:0]  rx_desc_ptr_out,
    output logic                       irq_out
);
    import pdrsis_pkg::*;

    localparam int VW = 3 + AW + DW;

    // ****************************************
    // event decode
    // ****************************************
    function automatic logic [31:0] ev_bits(
        input logic done, input logic pci, input logic irq,
        input logic err, input logic nul, input int base);
        logic [31:0] v;
        int          b;
        v = 32'h0000_0000;
        b = base + (pci ? ST_PCI_OFS : 0);
        if (done) begin
            v[b + EV_IRQ] = irq;
            v[b + EV_OK]  = !err;
            v[b + EV_ERR] = err;
            v[b + EV_EOL] = nul;
        end
        return v;
    endfunction

    // ****************************************
    // link synchroniser
    // ****************************************
    logic [VW-1:0] s1_q, s2_q, s3_q;
    logic          lclk_lvl_q;
    logic [2:0]    inta_s_q;
    logic          inta_lvl_q;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_q       <= '0;
            s2_q       <= '0;
            s3_q       <= '0;
            lclk_lvl_q <= 1'b0;
            inta_s_q   <= 3'h7;
            inta_lvl_q <= 1'b1;
        end else begin
            s1_q <= {link.lnk_clk, link.lnk_req, link.lnk_wr,
                     link.lnk_addr, link.lnk_wdata};
            s2_q <= s1_q;
            s3_q <= s2_q;
            inta_s_q <= {inta_s_q[1:0], inta_n_in};
            if (s2_q[VW-1] == s3_q[VW-1]) begin
                lclk_lvl_q <= s3_q[VW-1];
            end
            if (inta_s_q[1] == inta_s_q[2]) begin
                inta_lvl_q <= inta_s_q[2];
            end
        end
    end

    wire          lrise  = s2_q[VW-1] && s3_q[VW-1] && !lclk_lvl_q;
    wire          take   = lrise && s3_q[VW-2];
    wire          wr_tk  = take && s3_q[VW-3];
    wire [AW-1:0] addr   = s3_q[DW +: AW];
    wire [DW-1:0] wdata  = s3_q[DW-1:0];

    wire wr_run  = wr_tk && (addr == OFS_RX_ENABLE);
    wire wr_stop = wr_tk && (addr == OFS_RX_DISABLE);
    wire wr_ptr  = wr_tk && (addr == OFS_RX_DPTR);
    wire wr_sts  = wr_tk && (addr == OFS_STATUS);
    wire wr_msk  = wr_tk && (addr == OFS_MASK);
    wire wr_ien  = wr_tk && (addr == OFS_IRQ_EN);

    // ****************************************
    // registers
    // ****************************************
    logic              run_q, stop_q, irq_q;
    logic [DW-1:PTR_LSB] ptr_q;
    logic [DW-1:0]     sts_q, msk_q, ien_q, rdata_q;
    logic              run_d;
    logic [DW-1:0]     sts_d, ev;

    // stop in progress ignores writes to the enable a
    // write of zero there is treated the same way
    wire run_set = wr_run && wdata[RUN_BIT] && !stop_q;
    // endpoint drained while stopping: drop the run flag
    wire run_clr = stop_q && rx_idle_in;

    assign run_d = run_clr ? 1'b0 : (run_set ? 1'b1 : run_q);

    assign ev = ev_bits(tx_done_in, tx_pci_in, tx_irq_req_in,
                        tx_err_in, tx_null_link_in, ST_TX_BASE)
              | ev_bits(rx_done_in, rx_pci_in, rx_irq_req_in,
                        rx_err_in, rx_null_link_in, ST_RX_BASE)
              | (32'(tx_starve_in) << ST_TX_STARVE)
              | (32'(rx_starve_in) << ST_RX_STARVE)
              | (32'(mabort_in) << ST_MABORT);
    // ..come from the same decode above

    // write-one clear, a same-cycle event wins; masks play no part
    assign sts_d = ((sts_q & ~(wr_sts ? wdata : 32'h0000_0000)) | ev)
                 & ST_USED & ~(32'h1 << ST_EXT_INT);

    // external interrupt is a live level, not sticky
    wire ext_int = host_mode_in && !inta_lvl_q;
    wire [DW-1:0] sts_rd = sts_q | (32'(ext_int) << ST_EXT_INT);
    wire irq_d = ien_q[GIE_BIT] && |(sts_rd & msk_q);

    wire [DW-1:0] rd_val =
        (addr == OFS_RX_ENABLE)  ? 32'(run_q)  :
        (addr == OFS_RX_DISABLE) ? 32'(stop_q) :
        (addr == OFS_RX_DPTR)    ? {ptr_q, 2'b00} :
        (addr == OFS_STATUS)     ? sts_rd :
        (addr == OFS_MASK)       ? msk_q :
        (addr == OFS_IRQ_EN)     ? ien_q : 32'h0000_0000;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_q   <= 1'b0;
            stop_q  <= 1'b0;
            ptr_q   <= '0;
            sts_q   <= REG_RESET;
            msk_q   <= REG_RESET;
            ien_q   <= REG_RESET;
            irq_q   <= 1'b0;
            rdata_q <= REG_RESET;
        end else begin
            run_q <= run_d;
            sts_q <= sts_d;
            irq_q <= irq_d;
            if (wr_stop) begin
                stop_q <= wdata[STOP_BIT];
            end
            // engine advance takes priority over a software write
            if (rx_ptr_load_in) begin
                ptr_q <= rx_ptr_next_in[DW-1:PTR_LSB];
            end else if (wr_ptr) begin
                ptr_q <= wdata[DW-1:PTR_LSB];
            end
            if (wr_msk) begin
                msk_q <= wdata & ST_USED;
            end
            if (wr_ien) begin
                ien_q <= 32'(wdata[GIE_BIT]);
            end
            if (take) begin
                rdata_q <= rd_val;
            end
        end
    end

    assign link.lnk_rdata   = rdata_q;
    assign rx_run_out       = run_q;
    assign rx_stop_req_out  = stop_q;
    assign rx_desc_ptr_out  = {ptr_q, 2'b00};
    assign irq_out          = irq_q;
endmodule
`default_nettype wire

// ### rtl/pdrsis_ctl.sv
// controller end: drives the link and runs the rx stop sequence
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module pdrsis_ctl #(
    parameter int HALF = pdrsis_pkg::LINK_HALF
) (
    // clock and reset
    input  wire logic                      sys_clk_in,
    input  wire logic                      rst_in,
    // software register port
    input  wire logic [7:0]                reg_addr_in,
    input  wire logic [pdrsis_pkg::DW-1:0] reg_wdata_in,
    input  wire logic                      reg_wr_in,
    input  wire logic                      reg_rd_in,
    output logic [pdrsis_pkg::DW-1:0]      reg_rdata_out,
    // link to the device
    pdrsis_link_if.ctl                     link
);
    import pdrsis_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SW   = 3'b001,
        H_SET  = 3'b010,
        H_POLL = 3'b011,
        H_CLR  = 3'b100
    } pdrsis_st_t;

    // ****************************************
    // link clock divider
    // ****************************************
    logic [7:0] cnt_q;
    logic       lclk_q;
    wire        wrap = (cnt_q == 8'(HALF - 1));
    wire        fall = wrap && lclk_q;

    // ****************************************
    // answer synchroniser
    // ****************************************
    logic [DW-1:0] r1_q, r2_q, r3_q;

    // ****************************************
    // sequencer and transfer engine
    // ****************************************
    pdrsis_st_t    st_q;
    logic          req_q, wr_q, done_q, refused_q, stop_sh_q;
    logic [AW-1:0] addr_q, sw_addr_q;
    logic [DW-1:0] wdata_q, sw_wdata_q, rdata_q;
    logic          sw_wr_q;

    wire idle   = (st_q == H_IDLE);
    wire w_cmd  = reg_wr_in && (reg_addr_in == H_OFS_CMD);
    wire w_wdat = reg_wr_in && (reg_addr_in == H_OFS_WDATA);
    wire w_stop = reg_wr_in && (reg_addr_in == H_OFS_STOP);
    wire c_wr   = reg_wdata_in[CMD_WR_BIT];
    wire [AW-1:0] c_addr = reg_wdata_in[AW-1:0];
    // enable write of one during a stop is held back
    // the run bit lives in the staged data word, not in the command word
    wire bad_cmd = c_wr && stop_sh_q && (c_addr == OFS_RX_ENABLE);
    wire bad_run = sw_wdata_q[RUN_BIT] && stop_sh_q;
    wire fin     = fall && req_q;
    wire launch  = fall && !req_q && !idle;

    wire [DW-1:0] stat_val = {28'h0, stop_sh_q, refused_q, done_q, !idle};
    wire [DW-1:0] rd_val =
        (reg_addr_in == H_OFS_WDATA) ? sw_wdata_q :
        (reg_addr_in == H_OFS_RDATA) ? rdata_q :
        (reg_addr_in == H_OFS_STAT)  ? stat_val : 32'h0000_0000;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q  <= 8'h00;
            lclk_q <= 1'b0;
            r1_q   <= '0;
            r2_q   <= '0;
            r3_q   <= '0;
        end else begin
            cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
            if (wrap) begin
                lclk_q <= !lclk_q;
            end
            r1_q <= link.lnk_rdata;
            r2_q <= r1_q;
            r3_q <= r2_q;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q          <= H_IDLE;
            req_q         <= 1'b0;
            wr_q          <= 1'b0;
            addr_q        <= '0;
            wdata_q       <= '0;
            sw_wr_q       <= 1'b0;
            sw_addr_q     <= '0;
            sw_wdata_q    <= '0;
            rdata_q       <= '0;
            done_q        <= 1'b0;
            refused_q     <= 1'b0;
            stop_sh_q     <= 1'b0;
            reg_rdata_out <= '0;
        end else begin
            reg_rdata_out <= reg_rd_in ? rd_val : 32'h0000_0000;
            if (w_wdat && idle) begin
                sw_wdata_q <= reg_wdata_in;
            end
            if (w_cmd && idle) begin
                if (bad_cmd && bad_run) begin
                    refused_q <= 1'b1;
                end else begin
                    st_q      <= H_SW;
                    sw_wr_q   <= c_wr;
                    sw_addr_q <= c_addr;
                    done_q    <= 1'b0;
                    refused_q <= 1'b0;
                end
            end else if (w_stop && idle) begin
                st_q   <= H_SET;
                done_q <= 1'b0;
            end
            if (launch) begin
                req_q <= 1'b1;
                case (st_q)
                    H_SW: begin
                        wr_q    <= sw_wr_q;
                        addr_q  <= sw_addr_q;
                        wdata_q <= sw_wdata_q;
                    end
                    H_SET: begin
                        wr_q      <= 1'b1;
                        addr_q    <= OFS_RX_DISABLE;
                        wdata_q   <= 32'h0000_0001;
                        stop_sh_q <= 1'b1;
                    end
                    H_POLL: begin
                        wr_q   <= 1'b0;
                        addr_q <= OFS_RX_ENABLE;
                    end
                    H_CLR: begin
                        wr_q    <= 1'b1;
                        addr_q  <= OFS_RX_DISABLE;
                        wdata_q <= 32'h0000_0000;
                    end
                    default: begin
                        wr_q <= 1'b0;
                    end
                endcase
            end else if (fin) begin
                req_q   <= 1'b0;
                rdata_q <= r3_q;
                case (st_q)
                    H_SW: begin
                        st_q   <= H_IDLE;
                        done_q <= 1'b1;
                        if (sw_wr_q && sw_addr_q == OFS_RX_DISABLE) begin
                            stop_sh_q <= sw_wdata_q[STOP_BIT];
                        end
                    end
                    H_SET: begin
                        st_q <= H_POLL;
                    end
                    H_POLL: begin
                        // keep polling until the run flag reads clear
                        st_q <= r3_q[RUN_BIT] ? H_POLL : H_CLR;
                    end
                    H_CLR: begin
                        st_q      <= H_IDLE;
                        stop_sh_q <= 1'b0;
                        done_q    <= 1'b1;
                    end
                    default: begin
                        st_q <= H_IDLE;
                    end
                endcase
            end
        end
    end

    assign link.lnk_clk   = lclk_q;
    assign link.lnk_req   = req_q;
    assign link.lnk_wr    = wr_q;
    assign link.lnk_addr  = addr_q;
    assign link.lnk_wdata = wdata_q;
endmodule
`default_nettype wire

// ### test/pdrsis_assertions.sv
// concurrent checks on the link and the rx endpoint ports
`timescale 1ns/10ps
`default_nettype none
module pdrsis_assertions (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    // link
    input  wire logic        lnk_req,
    input  wire logic        lnk_wr,
    input  wire logic [11:0] lnk_addr,
    input  wire logic [31:0] lnk_wdata,
    // rx endpoint
    input  wire logic        rx_idle_in,
    input  wire logic        rx_ptr_load_in,
    input  wire logic [31:0] rx_ptr_next_in,
    input  wire logic        rx_run_out,
    input  wire logic        rx_stop_req_out,
    input  wire logic [31:0] rx_desc_ptr_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // ****************************************
    // link framing
    // ****************************************
    sequence s_req_open;
        $rose(lnk_req);
    endsequence
    sequence s_req_shut;
        $fell(lnk_req);
    endsequence
    // a lower and an upper bound on length: the divider phase may shift the fall
    chk_req_length: assert property (
        s_req_open |-> lnk_req[*8] ##[1:20] !lnk_req)
        else $error("link request length wrong");
    chk_req_gap: assert property (s_req_shut |-> !lnk_req[*8])
        else $error("link request gap too short");
    chk_req_stable: assert property (lnk_req && $past(lnk_req) |->
        $stable(lnk_addr) && $stable(lnk_wr) && $stable(lnk_wdata))
        else $error("link request changed while held");
    // ****************************************
    // rx stop and pointer
    // ****************************************
    chk_run_clears: assert property (
        rx_stop_req_out && rx_idle_in |=> !rx_run_out)
        else $error("run flag not cleared after stop");
    chk_run_no_rise: assert property (
        $rose(rx_run_out) |-> !$past(rx_stop_req_out))
        else $error("run flag set while stopping");
    chk_run_no_fall: assert property (
        $fell(rx_run_out) |-> $past(rx_stop_req_out) && $past(rx_idle_in))
        else $error("run flag dropped without stop");
    chk_stop_release: assert property (
        rx_stop_req_out && !rx_run_out |-> ##[1:1000] !rx_stop_req_out)
        else $error("stop bit not released");
    // link writes land only while a request is up
    chk_ptr_hold: assert property (
        !rx_ptr_load_in && !lnk_req |=> $stable(rx_desc_ptr_out))
        else $error("pointer changed with no cause");
    chk_ptr_load: assert property (
        rx_ptr_load_in |=> rx_desc_ptr_out[31:2] == $past(rx_ptr_next_in[31:2]))
        else $error("pointer not loaded by engine");
endmodule
`default_nettype wire

// ### test/pci_dma_rx_stop_irq_status_test.sv
// self-checking bench: controller and device joined by the link
`timescale 1ns/10ps
`default_nettype none
module pci_dma_rx_stop_irq_status_test
    import pdrsis_pkg::*;
;
    logic        sys_clk_in, rst_in, reg_wr, reg_rd, rx_ptr_load, rx_idle;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rx_ptr_next, rx_ptr, q;
    logic        tx_done, tx_pci, tx_irq, tx_err, tx_nul, tx_starve;
    logic        rx_done, rx_pci, rx_irq, rx_err, rx_nul, rx_starve;
    logic        host_mode, inta_n, mabort, rx_run, rx_stop, irq;
    int          fail_count = 0;
    int          tests_run = 0;
    int          i, n;
    pdrsis_link_if pdrsis_link_if_i ();
    pdrsis_ctl pdrsis_ctl_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .link(pdrsis_link_if_i));
    pdrsis_dev pdrsis_dev_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .link(pdrsis_link_if_i), .tx_done_in(tx_done), .tx_pci_in(tx_pci),
        .tx_irq_req_in(tx_irq), .tx_err_in(tx_err), .tx_null_link_in(tx_nul),
        .tx_starve_in(tx_starve), .rx_done_in(rx_done), .rx_pci_in(rx_pci),
        .rx_irq_req_in(rx_irq), .rx_err_in(rx_err), .rx_null_link_in(rx_nul),
        .rx_starve_in(rx_starve), .rx_idle_in(rx_idle),
        .rx_ptr_load_in(rx_ptr_load), .rx_ptr_next_in(rx_ptr_next),
        .host_mode_in(host_mode), .inta_n_in(inta_n), .mabort_in(mabort),
        .rx_run_out(rx_run), .rx_stop_req_out(rx_stop),
        .rx_desc_ptr_out(rx_ptr), .irq_out(irq));
    pdrsis_assertions pdrsis_assertions_i (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .lnk_req(pdrsis_link_if_i.lnk_req),
        .lnk_wr(pdrsis_link_if_i.lnk_wr), .lnk_addr(pdrsis_link_if_i.lnk_addr),
        .lnk_wdata(pdrsis_link_if_i.lnk_wdata), .rx_idle_in(rx_idle),
        .rx_ptr_load_in(rx_ptr_load), .rx_ptr_next_in(rx_ptr_next),
        .rx_run_out(rx_run), .rx_stop_req_out(rx_stop),
        .rx_desc_ptr_out(rx_ptr));
    // ****************************************
    // access tasks
    // ****************************************
    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge sys_clk_in);
    endtask
    task automatic wait_busy();
        logic [31:0] s;
        repeat (3) @(posedge sys_clk_in);
        for (int k = 0; k < 300; k++) begin
            reg_read(H_OFS_STAT, s);
            if (s[HS_BUSY] === 1'b0) break;
        end
        check("ctl busy", 32'h0, {31'h0, s[HS_BUSY]});
    endtask
    // one device transfer: data word first, then the command starts it
    task automatic dev_acc(input logic wr, input logic [11:0] a,
                           input logic [31:0] d, output logic [31:0] r);
        reg_write(H_OFS_WDATA, d);
        reg_write(H_OFS_CMD, {15'h0, wr, 4'h0, a});
        wait_busy();
        reg_read(H_OFS_RDATA, r);
    endtask
    task automatic dev_wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        dev_acc(1'b1, a, d, r);
    endtask
    task automatic expect_dev(input logic [11:0] a, input logic [31:0] e,
                              input string nm);
        logic [31:0] r;
        dev_acc(1'b0, a, 32'h0, r);
        check(nm, e, r);
    endtask
    task automatic fire(input logic rx, input logic pci, input logic [2:0] f);
        @(posedge sys_clk_in);
        if (rx) begin
            {rx_done, rx_pci, rx_irq, rx_err, rx_nul} <= {1'b1, pci, f};
        end else begin
            {tx_done, tx_pci, tx_irq, tx_err, tx_nul} <= {1'b1, pci, f};
        end
        @(posedge sys_clk_in);
        {rx_done, tx_done} <= 2'h0;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // clock, watchdog and tests
    // ****************************************
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        #500000;
        fail_count++;
        give_verdict();
    end
    initial begin
        rst_in = 1'b1;
        {reg_wr, reg_rd, rx_ptr_load, rx_idle, host_mode, mabort} = 6'h0;
        {tx_done, tx_pci, tx_irq, tx_err, tx_nul, tx_starve} = 6'h0;
        {rx_done, rx_pci, rx_irq, rx_err, rx_nul, rx_starve} = 6'h0;
        {reg_addr, reg_wdata, rx_ptr_next} = 72'h0;
        inta_n = 1'b1;
        repeat (20) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(posedge sys_clk_in);
        check("stop flag", 32'h0, {31'h0, rx_stop});
        expect_dev(OFS_RX_DISABLE, 32'h0, "stop reg");
        expect_dev(OFS_STATUS, 32'h0, "status");
        reg_read(8'hFC, q);
        check("ctl unmapped", 32'h0, q);
        expect_dev(12'h600, 32'h0, "dev unmapped");
        dev_wr(OFS_RX_DPTR, 32'h1234_567F);
        expect_dev(OFS_RX_DPTR, 32'h1234_567C, "pointer");
        check("pointer out", 32'h1234_567C, rx_ptr);
        rx_ptr_load <= 1'b1;
        rx_ptr_next <= 32'hABCD_0003;
        @(posedge sys_clk_in);
        rx_ptr_load <= 1'b0;
        @(posedge sys_clk_in);
        check("pointer load", 32'hABCD_0000, rx_ptr);
        // odd i: errored, null link; even i: irq request, clean
        for (i = 0; i < 8; i++) begin
            fire(i[2], i[1], i[0] ? 3'h3 : 3'h4);
            q = (i[0] ? 32'hC : 32'h3) << ((i[2] ? 4 : 0) + (i[1] ? 16 : 0));
            expect_dev(OFS_STATUS, q, "event");
            dev_wr(OFS_STATUS, 32'hFFFF_FFFF);
            expect_dev(OFS_STATUS, 32'h0, "cleared");
        end
        for (i = 0; i < 3; i++) begin
            @(posedge sys_clk_in);
            {tx_starve, rx_starve, mabort} <= 3'h4 >> i;
            @(posedge sys_clk_in);
            {tx_starve, rx_starve, mabort} <= 3'h0;
            q = 32'h1 << (i == 0 ? 9 : (i == 1 ? 24 : 26));
            expect_dev(OFS_STATUS, q, "starve abort");
            dev_wr(OFS_STATUS, 32'hFFFF_FFFF);
        end
        inta_n <= 1'b0;
        expect_dev(OFS_STATUS, 32'h0, "client ext");
        host_mode <= 1'b1;
        expect_dev(OFS_STATUS, 32'h0200_0000, "host ext");
        inta_n <= 1'b1;
        expect_dev(OFS_STATUS, 32'h0, "host idle");
        host_mode <= 1'b0;
        fire(1'b0, 1'b0, 3'h4);
        dev_wr(OFS_IRQ_EN, 32'h1);
        check("irq masked", 32'h0, {31'h0, irq});
        expect_dev(OFS_STATUS, 32'h3, "masked status");
        dev_wr(OFS_MASK, 32'h0000_0002);
        check("irq on", 32'h1, {31'h0, irq});
        dev_wr(OFS_IRQ_EN, 32'h0);
        check("irq global", 32'h0, {31'h0, irq});
        dev_wr(OFS_IRQ_EN, 32'h1);
        dev_wr(OFS_STATUS, 32'h0000_0002);
        check("irq cleared", 32'h0, {31'h0, irq});
        expect_dev(OFS_STATUS, 32'h1, "partial clear");
        dev_wr(OFS_RX_ENABLE, 32'h1);
        dev_wr(OFS_RX_DISABLE, 32'hFFFF_FFFF);
        expect_dev(OFS_RX_DISABLE, 32'h1, "stop reg");
        check("stop out", 32'h1, {31'h0, rx_stop});
        dev_wr(OFS_RX_ENABLE, 32'h0);
        expect_dev(OFS_RX_ENABLE, 32'h1, "run kept");
        dev_wr(OFS_RX_ENABLE, 32'h1);
        reg_read(H_OFS_STAT, q);
        check("refused", 32'h1, {31'h0, q[HS_REFUSED]});
        rx_idle <= 1'b1;
        expect_dev(OFS_RX_ENABLE, 32'h0, "run polled");
        dev_wr(OFS_RX_DISABLE, 32'h0);
        check("stop out", 32'h0, {31'h0, rx_stop});
        dev_wr(OFS_RX_ENABLE, 32'h1);
        check("run out", 32'h1, {31'h0, rx_run});
        reg_write(H_OFS_STOP, 32'h1);
        for (n = 0; n < 2000 && rx_stop !== 1'b1; n++) @(posedge sys_clk_in);
        for (n = 0; n < 2000 && rx_stop !== 1'b0; n++) @(posedge sys_clk_in);
        wait_busy();
        check("run after stop", 32'h0, {31'h0, rx_run});
        check("stop released", 32'h0, {31'h0, rx_stop});
        give_verdict();
    end
endmodule
`default_nettype wire
